// ### verilog/rx_err_pkg.sv
package rx_err_pkg;

   // Register byte addresses on the bus.
   localparam logic [7:0]  LBEM_ADDR       = 8'h18;
   localparam logic [7:0]  STATUS_ADDR     = 8'h1c;

   // Bit positions of the loopback, bypass and error mask register.
   localparam int          ALT_CARRIER_BIT = 6;
   localparam int          LOOP_TX_DIS_BIT = 5;
   localparam int          CODE_SEL_BIT    = 4;
   localparam int          EARLY_SEL_BIT   = 3;
   localparam int          LINK_EN_BIT     = 2;
   localparam int          PKT_EN_BIT      = 1;
   localparam logic [15:0] LBEM_RESET      = 16'h0020;
   localparam logic [15:0] LBEM_IMPL_MASK  = 16'h007f;

   // Bit positions of the status register.
   localparam int          ST_CRS_BIT      = 0;
   localparam int          ST_TXEN_BIT     = 1;
   localparam int          ST_FRAME_BIT    = 2;
   localparam int          ST_TIMEOUT_BIT  = 3;

   // Nibbles substituted on the receive data for each error kind.
   localparam logic [3:0]  CODE_ERR_ALT    = 4'h5;
   localparam logic [3:0]  DEFAULT_ERR     = 4'h6;
   localparam logic [3:0]  EARLY_ERR_ALT   = 4'h4;
   localparam logic [3:0]  LINK_ERR_VAL    = 4'h3;
   localparam logic [3:0]  TIMEOUT_ERR_VAL = 4'h2;

   // Packet timeout, a least time, rounded up to whole clock cycles.
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          PKT_TIMEOUT_NS  = 722000;
   localparam int          PKT_TIMEOUT_CYC = (PKT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Buffer word layout: data valid, error flag, nibble.
   localparam int          W_DV            = 5;
   localparam int          W_ER            = 4;
   localparam logic [1:0]  BUF_DEPTH       = 2'h2;

   typedef enum logic [1:0] {
      PE_OFF   = 2'b00,
      PE_DATA  = 2'b01,
      PE_IDLE1 = 2'b10,
      PE_GOT_T = 2'b11
   } pe_state_t;

endpackage : rx_err_pkg

// ### verilog/rx_error_crs_loopback_ctrl.sv
`timescale 1ns/1ns
// How it works
// - Alternate carrier select set in full duplex: carrier follows transmit, not reception.
// - Alternate carrier select clear in full duplex: carrier follows line reception only.
// - Loop transmit disable set (reset value) keeps line transmit off in loopback.
// - Loop transmit disable clear keeps line transmit on during loopback.
// - Internal loopback uses loop transmit disable to gate traffic onto the line.
// - Code error gives receive error with nibble 5h when selected, else 6h.
// - Premature end gives receive error with nibble 4h when selected, else 6h.
// - Two idle symbols before the T then R delimiter mean premature end.
// - Link error reported as 3h with receive error when enabled, else passed.
// - Packet timeout of 722 us reported as 2h when enabled, else passed.
module rx_error_crs_loopback_ctrl #(
   parameter int TIMEOUT_CYCLES = rx_err_pkg::PKT_TIMEOUT_CYC,
   parameter int CNT_W          = 16
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        full_duplex_in,
   input  wire logic        tx_en_in,
   input  wire logic        rx_carrier_in,
   input  wire logic        int_loopback_in,
   input  wire logic        ext_loopback_in,
   output logic             crs_out,
   output logic             tx_line_enable_out,
   input  wire logic        rx_valid_in,
   output logic             rx_ready_out,
   input  wire logic [3:0]  rx_nibble_in,
   input  wire logic        rx_dv_in,
   input  wire logic        code_err_in,
   input  wire logic        link_err_in,
   input  wire logic        sym_idle_in,
   input  wire logic        sym_t_in,
   input  wire logic        sym_r_in,
   output logic             mii_valid_out,
   input  wire logic        mii_ready_in,
   output logic      [3:0]  mii_rxd_out,
   output logic             mii_rx_er_out,
   output logic             mii_rx_dv_out
);
   import rx_err_pkg::*;

   typedef struct packed {
      logic [15:0]      ctrl;
      logic [1:0][5:0]  mem;
      logic [1:0]       count;
      logic             rdy;
      logic             vld;
      pe_state_t        pe;
      logic             frame;
      logic [CNT_W-1:0] tcnt;
      logic             thit;
      logic             crs;
      logic             txen;
      logic             ack;
      logic [31:0]      rdata;
   } state_t;

   state_t     st;
   state_t     next_st;
   logic       in_fire;
   logic       pop;
   logic       early_end;
   logic [5:0] word;

   function automatic logic [3:0] pick(input logic sel, input logic [3:0] alt);
      pick = sel ? alt : DEFAULT_ERR;
   endfunction : pick

   always_comb begin
      next_st   = st;
      in_fire   = rx_valid_in && st.rdy;
      pop       = (st.count != 2'h0) && mii_ready_in;
      early_end = 1'b0;

      // Bus slave: one wait state, then ack for one cycle; writes land on the ack edge.
      next_st.ack = wb_cyc_in && wb_stb_in && !st.ack;
      if (wb_cyc_in && wb_stb_in && !st.ack) begin
         next_st.rdata = 32'h0;
         if (wb_adr_in[7:2] == LBEM_ADDR[7:2]) begin
            next_st.rdata[15:0] = st.ctrl;
         end else if (wb_adr_in[7:2] == STATUS_ADDR[7:2]) begin
            next_st.rdata[ST_CRS_BIT]     = st.crs;
            next_st.rdata[ST_TXEN_BIT]    = st.txen;
            next_st.rdata[ST_FRAME_BIT]   = st.frame;
            next_st.rdata[ST_TIMEOUT_BIT] = st.thit;
         end
      end
      // Bit 0 is kept as written; its value steers nothing.
      if (st.ack && wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in[7:2] == LBEM_ADDR[7:2] && wb_sel_in[0]) begin
         next_st.ctrl[7:0] = wb_dat_in[7:0] & LBEM_IMPL_MASK[7:0];
      end

      // Carrier sense; half duplex sees both directions.
      if (full_duplex_in) begin
         next_st.crs = st.ctrl[ALT_CARRIER_BIT] ? tx_en_in : rx_carrier_in;
      end else begin
         next_st.crs = tx_en_in || rx_carrier_in;
      end
      next_st.txen = !((int_loopback_in || ext_loopback_in) && st.ctrl[LOOP_TX_DIS_BIT]);

      // Packet timeout counts clock cycles while a frame is open.
      if (st.frame && !st.thit) begin
         if (st.tcnt == CNT_W'(TIMEOUT_CYCLES - 1)) begin
            next_st.thit = 1'b1;
         end else begin
            next_st.tcnt = st.tcnt + CNT_W'(1);
         end
      end

      // Premature end tracking over the accepted symbol stream.
      if (in_fire) begin
         next_st.frame = rx_dv_in;
         if (!rx_dv_in) begin
            next_st.tcnt = '0;
            next_st.thit = 1'b0;
         end
         case (st.pe)
            PE_OFF: begin
               if (rx_dv_in) begin
                  next_st.pe = PE_DATA;
               end
            end
            PE_DATA: begin
               if (sym_idle_in) begin
                  next_st.pe = PE_IDLE1;
               end else if (sym_t_in) begin
                  next_st.pe = PE_GOT_T;
               end
            end
            PE_IDLE1: begin
               if (sym_idle_in) begin
                  early_end  = 1'b1;
                  next_st.pe = PE_OFF;
               end else if (sym_t_in) begin
                  next_st.pe = PE_GOT_T;
               end else begin
                  next_st.pe = PE_DATA;
               end
            end
            PE_GOT_T: begin
               if (sym_r_in) begin
                  next_st.pe = PE_OFF;
               end else if (sym_idle_in) begin
                  next_st.pe = PE_IDLE1;
               end else begin
                  next_st.pe = PE_DATA;
               end
            end
            default: next_st.pe = PE_OFF;
         endcase
      end

      // Error substitution on the beat that carries the condition.
      word = {rx_dv_in, 1'b0, rx_nibble_in};
      if (code_err_in) begin
         word = {rx_dv_in, 1'b1, pick(st.ctrl[CODE_SEL_BIT], CODE_ERR_ALT)};
      end else if (early_end) begin
         word = {rx_dv_in, 1'b1, pick(st.ctrl[EARLY_SEL_BIT], EARLY_ERR_ALT)};
      end else if (link_err_in && st.ctrl[LINK_EN_BIT]) begin
         word = {rx_dv_in, 1'b1, LINK_ERR_VAL};
      end else if (st.thit && st.ctrl[PKT_EN_BIT]) begin
         word = {rx_dv_in, 1'b1, TIMEOUT_ERR_VAL};
      end

      // Two-entry buffer; the head word drives the receive outputs directly.
      if (pop) begin
         next_st.mem[0] = st.mem[1];
      end
      if (in_fire) begin
         next_st.mem[st.count - {1'b0, pop}] = word;
      end
      next_st.count = st.count + {1'b0, in_fire} - {1'b0, pop};
      next_st.rdy   = next_st.count != BUF_DEPTH;
      // The valid flag gets its own flop so that the output never glitches on a count change.
      next_st.vld   = next_st.count != 2'h0;

      if (rst_in) begin
         next_st       = '0;
         next_st.ctrl  = LBEM_RESET;
         next_st.pe    = PE_OFF;
         next_st.rdy   = 1'b1;
         next_st.txen  = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      st <= next_st;
   end

   assign wb_dat_out         = st.rdata;
   assign wb_ack_out         = st.ack;
   assign crs_out            = st.crs;
   assign tx_line_enable_out = st.txen;
   assign rx_ready_out       = st.rdy;
   assign mii_valid_out      = st.vld;
   assign mii_rxd_out        = st.mem[0][3:0];
   assign mii_rx_er_out      = st.mem[0][W_ER];
   assign mii_rx_dv_out      = st.mem[0][W_DV];

   AST_ALT_CARRIER_TX: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (st.ctrl[ALT_CARRIER_BIT] && full_duplex_in) |=> (crs_out == $past(tx_en_in)))
      else $error("Alternate carrier sense does not follow transmit.");

   AST_CRS_RX_ONLY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!st.ctrl[ALT_CARRIER_BIT] && full_duplex_in && tx_en_in && !rx_carrier_in) |=> !crs_out)
      else $error("Carrier sense raised by transmit in full duplex.");

   AST_LOOP_TX_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ext_loopback_in && st.ctrl[LOOP_TX_DIS_BIT]) |=> !tx_line_enable_out)
      else $error("Line transmit enabled during loopback while disabled.");

   AST_LOOP_TX_ON: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ext_loopback_in && !st.ctrl[LOOP_TX_DIS_BIT]) |=> tx_line_enable_out)
      else $error("Line transmit off during loopback while enabled.");

   AST_INT_LOOP_GATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(int_loopback_in) && !ext_loopback_in |=> (tx_line_enable_out == !$past(st.ctrl[LOOP_TX_DIS_BIT])))
      else $error("Internal loopback does not follow the transmit disable bit.");

   AST_CODE_ERR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (in_fire && code_err_in && st.count == 2'h0) |=> (mii_valid_out && mii_rx_er_out &&
      mii_rxd_out == ($past(st.ctrl[CODE_SEL_BIT]) ? 4'h5 : 4'h6)))
      else $error("Code error nibble or receive error wrong.");

   AST_EARLY_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (st.pe == PE_IDLE1 && in_fire && sym_idle_in && !code_err_in && st.count == 2'h0) |=>
      (mii_rx_er_out && mii_rxd_out == ($past(st.ctrl[EARLY_SEL_BIT]) ? 4'h4 : 4'h6)))
      else $error("Premature end not reported after two idle symbols.");

   AST_LINK_PASS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (in_fire && link_err_in && !code_err_in && !early_end && !st.thit && st.count == 2'h0) |=>
      (mii_rx_er_out == $past(st.ctrl[LINK_EN_BIT])) &&
      (mii_rxd_out == ($past(st.ctrl[LINK_EN_BIT]) ? 4'h3 : $past(rx_nibble_in))))
      else $error("Link error handling wrong.");

   AST_PKT_TIMEOUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(st.thit) |-> ($past(st.tcnt) == CNT_W'(TIMEOUT_CYCLES - 1) && $past(st.frame)))
      else $error("Packet timeout flagged at the wrong count.");

   AST_BUF_FULL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (st.count == 2'h2) |-> (!rx_ready_out ##1 (st.count != 2'h3)))
      else $error("Buffer accepts a word while full.");

   // Bus and reset checks guard the handshake that software relies on.
   // A stuck ack would hang every register access, so it is checked both ways.
   AST_ACK_PULSE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("Bus ack held longer than one cycle.");

   AST_ACK_AFTER_REQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
      else $error("Bus request not acknowledged in the next cycle.");

   AST_WRITE_LANDS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in[7:2] == LBEM_ADDR[7:2] && wb_sel_in[0]) |=>
      (st.ctrl[6:0] == $past(wb_dat_in[6:0])))
      else $error("Control write did not land.");

   AST_RESET_STATE: assert property (@(posedge ref_clk_in)
      rst_in |=> (!wb_ack_out && tx_line_enable_out && rx_ready_out && !mii_valid_out && st.ctrl == LBEM_RESET))
      else $error("State after reset wrong.");

   AST_HALF_DUPLEX_CRS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !full_duplex_in |=> (crs_out == ($past(tx_en_in) || $past(rx_carrier_in))))
      else $error("Half duplex carrier sense wrong.");

   AST_NO_LOOP_TX_ON: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!int_loopback_in && !ext_loopback_in) |=> tx_line_enable_out)
      else $error("Line transmit off outside loopback.");

   AST_BUF_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (mii_valid_out && !mii_ready_in) |=> (mii_valid_out && $stable(mii_rxd_out) && $stable(mii_rx_er_out)))
      else $error("Head word changed while stalled.");

   AST_READY_ROOM: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (st.count != 2'h2) |-> rx_ready_out)
      else $error("Ready low although the buffer has room.");

   AST_TIMEOUT_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (in_fire && !rx_dv_in) |=> (!st.thit && st.tcnt == '0))
      else $error("Timeout not cleared when the frame closed.");

   AST_T_R_CLOSES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (st.pe == PE_GOT_T && in_fire && sym_r_in) |=> (st.pe == PE_OFF))
      else $error("End delimiter did not close the frame.");

   AST_PKT_REPORT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (in_fire && st.thit && st.ctrl[PKT_EN_BIT] && !code_err_in && !early_end && !link_err_in &&
      st.count == 2'h0) |=> (mii_rx_er_out && mii_rxd_out == TIMEOUT_ERR_VAL))
      else $error("Packet timeout not reported.");

   AST_LINK_REPORT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (in_fire && link_err_in && st.ctrl[LINK_EN_BIT] && !code_err_in && !early_end && st.count == 2'h0) |=>
      (mii_rx_er_out && mii_rxd_out == LINK_ERR_VAL))
      else $error("Link error not reported.");

endmodule : rx_error_crs_loopback_ctrl

// ### sim/mac_rx_model.sv
`timescale 1ns/1ns
module mac_rx_model (
   input  wire logic       clk_in,
   input  wire logic       stall_in,
   input  wire logic       slow_in,
   input  wire logic       valid_in,
   input  wire logic [3:0] rxd_in,
   input  wire logic       er_in,
   input  wire logic       dv_in,
   output logic            ready_out
);
   logic [5:0] got[$];
   logic [2:0] pace;
   initial begin
      ready_out = 1'b0;
      pace = 3'h0;
   end
   // A slow receiver takes one word in eight, so the buffer must hold what it cannot pass on.
   always @(posedge clk_in) begin
      if (valid_in && ready_out) begin
         got.push_back({dv_in, er_in, rxd_in});
      end
      pace <= pace + 3'h1;
      ready_out <= !stall_in && (!slow_in || pace == 3'h0);
   end
endmodule : mac_rx_model

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import rx_err_pkg::*;
   logic        ref_clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
   logic [7:0]  wb_adr_in;
   logic [3:0]  wb_sel_in, rx_nibble_in, mii_rxd_out;
   logic [31:0] wb_dat_in, wb_dat_out, lfsr, rd;
   logic        full_duplex_in, tx_en_in, rx_carrier_in, int_loopback_in, ext_loopback_in;
   logic        crs_out, tx_line_enable_out, rx_valid_in, rx_ready_out, rx_dv_in;
   logic        code_err_in, link_err_in, sym_idle_in, mii_valid_out, mii_ready_in, sym_t_in, sym_r_in;
   logic        mii_rx_er_out, mii_rx_dv_out, stall, slow;
   logic [6:0]  exp_q[$];
   int          mismatches, checked, cycles;

   rx_error_crs_loopback_ctrl #(.TIMEOUT_CYCLES(20), .CNT_W(16)) u_dut (
      .ref_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
      .wb_dat_out, .wb_ack_out, .full_duplex_in, .tx_en_in, .rx_carrier_in, .int_loopback_in,
      .ext_loopback_in, .crs_out, .tx_line_enable_out, .rx_valid_in, .rx_ready_out, .rx_nibble_in,
      .rx_dv_in, .code_err_in, .link_err_in, .sym_idle_in, .sym_t_in, .sym_r_in,
      .mii_valid_out, .mii_ready_in, .mii_rxd_out, .mii_rx_er_out, .mii_rx_dv_out);

   mac_rx_model u_mac (.clk_in(ref_clk_in), .stall_in(stall), .slow_in(slow), .valid_in(mii_valid_out),
      .rxd_in(mii_rxd_out), .er_in(mii_rx_er_out), .dv_in(mii_rx_dv_out), .ready_out(mii_ready_in));

   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand

   // Expected word is {care, dv, er, nibble}; kind 5 marks a beat whose outcome is left open.
   function automatic logic [6:0] exp_word(input int kind, input logic s, input logic dv, input logic [3:0] n);
      case (kind)
         1: return {1'b1, dv, 1'b1, s ? CODE_ERR_ALT : DEFAULT_ERR};
         2: return {1'b1, dv, 1'b1, s ? EARLY_ERR_ALT : DEFAULT_ERR};
         3: return s ? {1'b1, dv, 1'b1, LINK_ERR_VAL} : {1'b1, dv, 1'b0, n};
         4: return s ? {1'b1, dv, 1'b1, TIMEOUT_ERR_VAL} : {1'b1, dv, 1'b0, n};
         5: return 7'h00;
         default: return {1'b1, dv, 1'b0, n};
      endcase
   endfunction : exp_word

   task automatic give_verdict;
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      @(posedge ref_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_adr_in <= adr;
      wb_dat_in <= dat;
      wb_sel_in <= sel;
      do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask : wb

   // Valid stays up between beats so consecutive calls stream back to back.
   task automatic beat(input int kind, input logic s, input logic dv, input logic idle);
      lfsr = next_rand(lfsr);
      exp_q.push_back(exp_word(kind, s, dv, lfsr[3:0]));
      rx_valid_in  <= 1'b1;
      rx_nibble_in <= lfsr[3:0];
      rx_dv_in     <= dv;
      code_err_in  <= (kind == 1);
      link_err_in  <= (kind == 3);
      sym_idle_in  <= idle;
      sym_t_in     <= (kind == 6);
      sym_r_in     <= (kind == 7);
      do @(posedge ref_clk_in); while (rx_ready_out !== 1'b1);
   endtask : beat

   task automatic drain;
      while (u_mac.got.size() < exp_q.size()) @(posedge ref_clk_in);
      foreach (exp_q[i]) if (exp_q[i][6]) chk({26'h0, u_mac.got[i]}, {26'h0, exp_q[i][5:0]});
      exp_q.delete();
      u_mac.got.delete();
   endtask : drain

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in, full_duplex_in, tx_en_in} = '0;
      {rx_carrier_in, int_loopback_in, ext_loopback_in, rx_valid_in, rx_nibble_in, rx_dv_in} = '0;
      {code_err_in, link_err_in, sym_idle_in, sym_t_in, sym_r_in, stall, slow, mismatches, checked, cycles} = '0;
      lfsr = 32'h374c;
      rst_in = 1'b1;
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      wb(1'b0, LBEM_ADDR, 32'h0, 4'hf);
      chk(rd, {16'h0, LBEM_RESET});
      repeat (4) begin
         lfsr = next_rand(lfsr);
         wb(1'b1, LBEM_ADDR, lfsr & 32'hfffe, 4'hf);
         wb(1'b1, LBEM_ADDR, ~lfsr, 4'he);
         wb(1'b0, LBEM_ADDR, 32'h0, 4'hf);
         chk(rd, lfsr & 32'h007e);
      end
      wb(1'b0, 8'h20, 32'h0, 4'hf);
      chk(rd, 32'h0);
      for (int i = 0; i < 128; i++) begin
         wb(1'b1, LBEM_ADDR, {25'h0, i[0], i[1], 5'h0}, 4'h1);
         tx_en_in        <= i[2];
         rx_carrier_in   <= i[3];
         int_loopback_in <= i[4];
         ext_loopback_in <= i[5];
         full_duplex_in  <= i[6];
         repeat (2) @(posedge ref_clk_in);
         chk({31'h0, crs_out}, {31'h0, i[6] ? (i[0] ? i[2] : i[3]) : i[2] | i[3]});
         chk({31'h0, tx_line_enable_out}, {31'h0, !((i[4] | i[5]) & i[1])});
      end
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, LBEM_ADDR, s ? 32'h1e : 32'h0, 4'hf);
         beat(1, s[0], 1'b1, 1'b0);
         beat(3, s[0], 1'b1, 1'b0);
         beat(0, s[0], 1'b1, 1'b1);
         beat(2, s[0], 1'b1, 1'b1);
         beat(0, s[0], 1'b1, 1'b0);
         beat(6, s[0], 1'b1, 1'b0);
         beat(7, s[0], 1'b1, 1'b0);
         beat(0, s[0], 1'b1, 1'b1);
         beat(0, s[0], 1'b1, 1'b1);
         beat(0, s[0], 1'b0, 1'b0);
         beat(0, s[0], 1'b1, 1'b0);
         rx_valid_in <= 1'b0;
         repeat (30) @(posedge ref_clk_in);
         beat(4, s[0], 1'b1, 1'b0);
         beat(5, s[0], 1'b0, 1'b0);
         rx_valid_in <= 1'b0;
         drain();
      end
      stall <= 1'b1;
      beat(0, 1'b0, 1'b0, 1'b0);
      beat(0, 1'b0, 1'b0, 1'b0);
      rx_valid_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      chk({31'h0, rx_ready_out}, 32'h0);
      stall <= 1'b0;
      slow  <= 1'b1;
      repeat (16) beat(0, 1'b0, 1'b0, 1'b0);
      rx_valid_in <= 1'b0;
      drain();
      give_verdict();
   end
endmodule : testbench
